// file: logic/stc_pkg.sv
// constants and types of the sensitivity temperature compensation block
package stc_pkg;
  // ****************************************
  // register map (plain port, printed offsets)
  // ****************************************
  localparam logic [7:0] STC_TC2_ADDR = 8'h08;
  localparam logic [7:0] STC_TC1_ADDR = 8'h09;
  localparam logic [7:0] STC_CTRL_ADDR = 8'h0a;
  localparam logic [7:0] STC_STAT_ADDR = 8'h0b;
  localparam int STC_TC2_COLD_LSB = 6;
  localparam int STC_TC2_HOT_LSB = 15;
  localparam int STC_TC1_COLD_LSB = 8;
  localparam int STC_TC1_HOT_LSB = 16;
  localparam int STC_CTRL_MODE_BIT = 0;
  localparam int STC_STAT_READY_BIT = 0;
  localparam int STC_STAT_MODE_BIT = 1;
  localparam int STC_STAT_CODE_LSB = 4;
  localparam logic [7:0] STC_TC1_RESET = 8'h00;
  localparam logic [8:0] STC_TC2_RESET = 9'h000;
  localparam logic STC_MODE_RESET = 1'b0;
  // ****************************************
  // coefficient decode and arithmetic scale
  // ****************************************
  localparam logic signed [9:0] STC_TC1_ZERO = 10'sh040; // code giving 0 m%/C
  localparam logic signed [10:0] STC_TC2_MID2 = 11'sh1ff; // twice the mid code
  localparam int STC_GAIN_FRAC = 25; // gain lsb = 2^-25 = half a tc2 step
  localparam int STC_TC1_ALIGN = 9; // tc1 step = 2^-16 = 2^9 gain lsb
  localparam logic signed [27:0] STC_GAIN_ONE = 28'sh2000000;
  // ****************************************
  // output ranges
  // ****************************************
  localparam logic signed [15:0] STC_SENT_MIN = 16'sh0000;
  localparam logic signed [15:0] STC_SENT_MAX = 16'sh0fff;
  localparam logic signed [15:0] STC_SENT_MID = 16'sh0800;
  localparam logic [9:0] STC_PWM_MIN = 10'h032; // 5.0 percent in 0.1 units
  localparam logic [9:0] STC_PWM_MAX = 10'h3b6; // 95.0 percent
  localparam logic [9:0] STC_PWM_SPAN = 10'h384; // 90.0 percent
  // ****************************************
  // timing
  // ****************************************
  localparam int STC_CLK_MHZ = 100;
  localparam int STC_POWER_ON_TIME_US = 1000;
  localparam int STC_POWER_ON_CYCLES = STC_POWER_ON_TIME_US * STC_CLK_MHZ;
  localparam int STC_MSG_PERIOD_US = 100;
  localparam int STC_MSG_PERIOD_CYCLES = STC_MSG_PERIOD_US * STC_CLK_MHZ;
  typedef enum logic {STC_MODE_SENT, STC_MODE_PWM} stc_mode_t;
  typedef enum logic [1:0] {STC_ST_POWERUP, STC_ST_WAIT_DATA, STC_ST_RUN} stc_state_t;
endpackage : stc_pkg

// file: logic/stc_top.sv
// sensitivity temperature compensation core with output range shaping
// Functional notes
// R1: linear correction uses hot coefficient above 25 C, cold one below
// R2: hot and cold first-order coefficients are separate 8-bit unsigned codes
// R3: first-order code 0 is -98, all-ones +291, step 1.53 m%/C
// R4: quadratic correction uses hot coefficient above 25 C, cold below
// R5: hot and cold second-order coefficients are separate 9-bit codes
// R6: second-order code 0 is -1.53, all-ones +1.53, step 0.00596 m%/C
// R7: programmer writes zero to both first-order fields when unused
// R8: programmer writes zero to both second-order fields when unused
// R9: pwm duty over full-scale span is held between 5 and 95 percent
// R10: sent full-scale output codes run from 0 to 4095
// R11: no output until start-up done; first output already valid
// R12: slow updates make messages repeat the held value
// R13: at exactly 25 C no temperature correction is applied
module stc_top
  import stc_pkg::*;
#(
  parameter int POWER_ON_CYCLES = stc_pkg::STC_POWER_ON_CYCLES,
  parameter int MSG_PERIOD_CYCLES = stc_pkg::STC_MSG_PERIOD_CYCLES
) (
  input wire logic core_clk, // 100 MHz core clock
  input wire logic rst, // async reset, active high
  input wire logic [7:0] reg_addr, // register address
  input wire logic [23:0] reg_wdata, // register write data
  input wire logic reg_wr, // write strobe
  input wire logic reg_rd, // read strobe
  output logic [23:0] reg_rdata_q, // read data, cycle after strobe
  input wire logic signed [11:0] field_in, // filtered field reading
  input wire logic signed [7:0] temp_dev, // ambient minus 25 C, in C
  input wire logic sample_valid, // new filter update
  output logic [11:0] sent_code_q, // sent data value
  output logic [9:0] pwm_duty_q, // pwm duty, 0.1 percent units
  output logic msg_strobe_q, // one-cycle pulse per output message
  output logic out_ready_q // outputs valid
);
  import stc_pkg::*;

  // ****************************************
  // registers
  // ****************************************
  logic [7:0] tc1_cold_q;
  logic [7:0] tc1_hot_q;
  logic [8:0] tc2_cold_q;
  logic [8:0] tc2_hot_q;
  stc_mode_t mode_q;
  stc_state_t state_q;
  logic [31:0] por_cnt_q;
  logic [31:0] msg_cnt_q;
  logic signed [27:0] gain_q;
  logic signed [11:0] field_s1_q;
  logic s1_valid_q;
  logic signed [39:0] prod_q;
  logic s2_valid_q;
  logic [11:0] code_q;
  logic have_value_q;
  logic signed [9:0] tc1_sel;
  logic signed [10:0] tc2_sel;
  logic signed [27:0] corr;
  logic signed [15:0] scaled;
  logic [11:0] code_d;
  logic [21:0] pwm_prod;

  // register writes
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      tc1_cold_q <= STC_TC1_RESET;
      tc1_hot_q <= STC_TC1_RESET;
      tc2_cold_q <= STC_TC2_RESET;
      tc2_hot_q <= STC_TC2_RESET;
      mode_q <= STC_MODE_SENT;
    end else if (reg_wr) begin
      if (reg_addr == STC_TC1_ADDR) begin
        tc1_cold_q <= reg_wdata[STC_TC1_COLD_LSB +: 8]; // R2
        tc1_hot_q <= reg_wdata[STC_TC1_HOT_LSB +: 8]; // R2
      end
      if (reg_addr == STC_TC2_ADDR) begin
        tc2_cold_q <= reg_wdata[STC_TC2_COLD_LSB +: 9]; // R5
        tc2_hot_q <= reg_wdata[STC_TC2_HOT_LSB +: 9]; // R5
      end
      if (reg_addr == STC_CTRL_ADDR) begin
        mode_q <= stc_mode_t'(reg_wdata[STC_CTRL_MODE_BIT]);
      end
    end
  end

  // register reads, unmapped reads give zero
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      reg_rdata_q <= 24'h000000;
    end else if (reg_rd) begin
      reg_rdata_q <= 24'h000000;
      unique case (reg_addr)
        STC_TC1_ADDR: begin
          reg_rdata_q[STC_TC1_COLD_LSB +: 8] <= tc1_cold_q;
          reg_rdata_q[STC_TC1_HOT_LSB +: 8] <= tc1_hot_q;
        end
        STC_TC2_ADDR: begin
          reg_rdata_q[STC_TC2_COLD_LSB +: 9] <= tc2_cold_q;
          reg_rdata_q[STC_TC2_HOT_LSB +: 9] <= tc2_hot_q;
        end
        STC_CTRL_ADDR: begin
          reg_rdata_q[STC_CTRL_MODE_BIT] <= mode_q;
        end
        STC_STAT_ADDR: begin
          reg_rdata_q[STC_STAT_READY_BIT] <= out_ready_q;
          reg_rdata_q[STC_STAT_MODE_BIT] <= mode_q;
          reg_rdata_q[STC_STAT_CODE_LSB +: 12] <= code_q;
        end
        default: begin
          reg_rdata_q <= 24'h000000;
        end
      endcase
    end
  end

  // ****************************************
  // gain computation
  // ****************************************
  // coefficient pick by sign of deviation, decode to signed steps
  always_comb begin
    if (temp_dev > 8'sh00) begin
      tc1_sel = $signed({2'b00, tc1_hot_q}) - STC_TC1_ZERO; // R1 R3
      tc2_sel = $signed({1'b0, tc2_hot_q, 1'b0}) - STC_TC2_MID2; // R4 R6
    end else if (temp_dev < 8'sh00) begin
      tc1_sel = $signed({2'b00, tc1_cold_q}) - STC_TC1_ZERO; // R1 R3
      tc2_sel = $signed({1'b0, tc2_cold_q, 1'b0}) - STC_TC2_MID2; // R4 R6
    end else begin
      tc1_sel = 10'sh000; // R13
      tc2_sel = 11'sh000; // R13
    end
    corr = (28'(tc1_sel * temp_dev) <<< STC_TC1_ALIGN) + 28'(tc2_sel * temp_dev * temp_dev);
  end

  // stage one: gain and field capture
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      gain_q <= STC_GAIN_ONE;
      field_s1_q <= 12'sh000;
      s1_valid_q <= 1'b0;
    end else begin
      s1_valid_q <= sample_valid;
      if (sample_valid) begin
        gain_q <= STC_GAIN_ONE + corr;
        field_s1_q <= field_in;
      end
    end
  end

  // stage two: apply gain
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      prod_q <= 40'sh0000000000;
      s2_valid_q <= 1'b0;
    end else begin
      s2_valid_q <= s1_valid_q;
      if (s1_valid_q) begin
        prod_q <= 40'(field_s1_q * gain_q);
      end
    end
  end

  // clamp to the sent full-scale span around mid code
  always_comb begin
    scaled = 16'(prod_q >>> STC_GAIN_FRAC) + STC_SENT_MID;
    if (scaled < STC_SENT_MIN) begin
      code_d = 12'h000; // R10
    end else if (scaled > STC_SENT_MAX) begin
      code_d = 12'hfff; // R10
    end else begin
      code_d = scaled[11:0];
    end
  end

  // stage three: held measurement value
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      code_q <= 12'h000;
      have_value_q <= 1'b0;
    end else if (s2_valid_q) begin
      code_q <= code_d;
      have_value_q <= 1'b1;
    end
  end

  // ****************************************
  // start-up and message timing
  // ****************************************
  // start-up sequence
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state_q <= STC_ST_POWERUP;
      por_cnt_q <= 32'h00000000;
    end else begin
      unique case (state_q)
        STC_ST_POWERUP: begin
          por_cnt_q <= por_cnt_q + 32'h00000001;
          if (por_cnt_q == 32'(POWER_ON_CYCLES - 1)) begin
            state_q <= STC_ST_WAIT_DATA; // R11
          end
        end
        STC_ST_WAIT_DATA: begin
          if (have_value_q) begin
            state_q <= STC_ST_RUN; // R11
          end
        end
        STC_ST_RUN: begin
          state_q <= STC_ST_RUN;
        end
      endcase
    end
  end

  assign pwm_prod = 22'(code_q * STC_PWM_SPAN);

  // message generation: repeats the held value until a new one lands
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      msg_cnt_q <= 32'h00000000;
      msg_strobe_q <= 1'b0;
      out_ready_q <= 1'b0;
      sent_code_q <= 12'h000;
      pwm_duty_q <= STC_PWM_MIN;
    end else begin
      msg_strobe_q <= 1'b0;
      if (state_q == STC_ST_RUN) begin
        if (msg_cnt_q == 32'h00000000) begin
          msg_strobe_q <= 1'b1; // R11 R12
          out_ready_q <= 1'b1;
          sent_code_q <= code_q; // R10 R12
          pwm_duty_q <= STC_PWM_MIN + pwm_prod[21:12]; // R9
        end
        if (msg_cnt_q == 32'(MSG_PERIOD_CYCLES - 1)) begin
          msg_cnt_q <= 32'h00000000;
        end else begin
          msg_cnt_q <= msg_cnt_q + 32'h00000001;
        end
      end
    end
  end

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  // coefficient pick and decode at spot codes; gain lsb is 2^-25
  hot_first_pick_a: assert property ( // R1
    sample_valid && temp_dev > 8'sh00 && tc2_hot_q == 9'h0ff && tc1_hot_q == 8'h40
    |=> gain_q == STC_GAIN_ONE - 28'($past(temp_dev) * $past(temp_dev)))
    else $error("hot coefficients not applied");
  cold_linear_pick_a: assert property ( // R1 R3
    sample_valid && temp_dev == -8'sd1 && tc2_cold_q == 9'h100 && tc1_cold_q == 8'h00
    |=> gain_q == STC_GAIN_ONE + 28'sh0008000 + 28'sh0000001)
    else $error("cold linear decode wrong");
  hot_quad_decode_a: assert property ( // R4 R6
    sample_valid && temp_dev == 8'sd2 && tc1_hot_q == 8'h40 && tc2_hot_q == 9'h1ff
    |=> gain_q == STC_GAIN_ONE + 28'sh00007fc)
    else $error("hot quadratic decode wrong");
  cold_ten_pick_a: assert property ( // R1 R3 R4 R6
    sample_valid && temp_dev == -8'sd10 && tc1_cold_q == 8'h00 && tc2_cold_q == 9'h000
    |=> gain_q == STC_GAIN_ONE + 28'sh0043864)
    else $error("cold pick at ten degrees wrong");
  room_temp_unity_a: assert property ( // R13
    sample_valid && temp_dev == 8'sh00 |=> gain_q == STC_GAIN_ONE)
    else $error("correction applied at 25 C");

  // coefficient storage and read-back
  field_width_a: assert property ( // R2
    reg_wr && reg_addr == STC_TC1_ADDR
    |=> tc1_hot_q == $past(reg_wdata[23:16]) && tc1_cold_q == $past(reg_wdata[15:8]))
    else $error("first-order fields not stored");
  coeff_width_a: assert property ( // R5
    reg_wr && reg_addr == STC_TC2_ADDR
    |=> tc2_hot_q == $past(reg_wdata[23:15]) && tc2_cold_q == $past(reg_wdata[14:6]))
    else $error("second-order fields not stored");
  first_readback_a: assert property ( // R2
    reg_rd && reg_addr == STC_TC1_ADDR |=> reg_rdata_q[STC_TC1_HOT_LSB +: 8] == $past(tc1_hot_q))
    else $error("first-order read-back wrong");

  // output ranges
  pwm_range_a: assert property ( // R9
    out_ready_q |-> pwm_duty_q >= STC_PWM_MIN && pwm_duty_q <= STC_PWM_MAX)
    else $error("pwm duty out of range");
  pwm_floor_a: assert property ( // R9
    msg_strobe_q && sent_code_q == 12'h000 |-> pwm_duty_q == STC_PWM_MIN)
    else $error("pwm duty not at floor");
  sent_range_a: assert property ( // R10
    s2_valid_q && scaled > STC_SENT_MAX |=> code_q == 12'hfff)
    else $error("sent code not clamped");
  sent_floor_a: assert property ( // R10
    s2_valid_q && scaled < STC_SENT_MIN |=> code_q == 12'h000)
    else $error("sent code not clamped at zero");

  // start-up and message timing
  no_early_msg_a: assert property ( // R11
    state_q != STC_ST_RUN |-> !msg_strobe_q && !out_ready_q)
    else $error("output before start-up done");
  por_hold_a: assert property ( // R11
    state_q == STC_ST_POWERUP && por_cnt_q != 32'(POWER_ON_CYCLES - 1) |=> state_q == STC_ST_POWERUP)
    else $error("start-up left too early");
  ready_stays_a: assert property ( // R11
    out_ready_q |=> out_ready_q)
    else $error("outputs valid dropped");
  first_msg_a: assert property ( // R11
    $rose(out_ready_q) |-> msg_strobe_q)
    else $error("outputs valid without a message");
  ready_status_a: assert property ( // R11
    reg_rd && reg_addr == STC_STAT_ADDR |=> reg_rdata_q[STC_STAT_READY_BIT] == $past(out_ready_q))
    else $error("status ready bit wrong");
  msg_spacing_a: assert property ( // R12
    msg_strobe_q && MSG_PERIOD_CYCLES > 1 |=> !msg_strobe_q)
    else $error("messages too close");
  msg_held_a: assert property ( // R12
    msg_strobe_q |-> sent_code_q == $past(code_q))
    else $error("message does not carry held value");
  code_change_a: assert property ( // R12
    $changed(sent_code_q) |-> msg_strobe_q)
    else $error("sent value changed between messages");
endmodule // stc_top

// file: test/stc_rx_model.sv
// receiving controller model: latches every output message
module stc_rx_model (
  input wire logic core_clk, // core clock
  input wire logic rst, // async reset
  input wire logic msg_strobe, // message pulse
  input wire logic out_ready, // outputs valid
  input wire logic [11:0] sent_code, // sent value
  input wire logic [9:0] pwm_duty, // pwm duty
  output logic [11:0] rx_sent, // last sent value taken
  output logic [9:0] rx_pwm, // last duty taken
  output int rx_count, // messages taken
  output logic early_msg // message seen before ready
);
  timeunit 1ns;
  timeprecision 1ps;
  // take each message at its pulse; repeats are counted as new messages
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rx_count <= 0;
      early_msg <= 1'b0;
      rx_sent <= 12'h000;
      rx_pwm <= 10'h000;
    end else if (msg_strobe) begin
      rx_count <= rx_count + 1;
      rx_sent <= sent_code;
      rx_pwm <= pwm_duty;
      if (!out_ready) begin
        early_msg <= 1'b1;
      end
    end
  end
endmodule // stc_rx_model

// file: test/test_sensitivity_temp_compensation.sv
// self-checking bench of the compensation core
module test_sensitivity_temp_compensation;
  import stc_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int PO = 20;
  localparam int MP = 8;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [23:0] reg_wdata = 24'h000000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic signed [11:0] field_in = 12'sh000;
  logic signed [7:0] temp_dev = 8'sh00;
  logic sample_valid = 1'b0;
  logic [23:0] reg_rdata_q;
  logic [11:0] sent_code_q;
  logic [11:0] rx_sent;
  logic [9:0] pwm_duty_q;
  logic [9:0] rx_pwm;
  logic msg_strobe_q;
  logic out_ready_q;
  logic early_msg;
  int rx_count;
  int n_errors = 0;
  int checks_done = 0;
  int cycles = 0;
  logic [23:0] v;
  always #5 core_clk = ~core_clk;
  stc_top #(.POWER_ON_CYCLES(PO), .MSG_PERIOD_CYCLES(MP)) stc_top_inst (.core_clk(core_clk), .rst(rst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q),
    .field_in(field_in), .temp_dev(temp_dev), .sample_valid(sample_valid), .sent_code_q(sent_code_q),
    .pwm_duty_q(pwm_duty_q), .msg_strobe_q(msg_strobe_q), .out_ready_q(out_ready_q));
  stc_rx_model stc_rx_model_inst (.core_clk(core_clk), .rst(rst), .msg_strobe(msg_strobe_q),
    .out_ready(out_ready_q), .sent_code(sent_code_q), .pwm_duty(pwm_duty_q), .rx_sent(rx_sent),
    .rx_pwm(rx_pwm), .rx_count(rx_count), .early_msg(early_msg));
  // ****************************************
  // shared tasks
  // ****************************************
  task automatic check(input logic [23:0] seen, input logic [23:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [23:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [23:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata_q;
  endtask
  task automatic wait_msgs(input int n);
    int start;
    start = rx_count;
    for (int i = 0; i < 40 * MP && rx_count < start + n; i++) begin
      @(posedge core_clk);
    end
    check(24'(rx_count >= start + n), 24'h000001);
    #1;
  endtask
  // one filter update, then two messages so the held code is out
  task automatic apply(input int f, input int t);
    @(posedge core_clk);
    field_in <= 12'(f);
    temp_dev <= 8'(t);
    sample_valid <= 1'b1;
    @(posedge core_clk);
    sample_valid <= 1'b0;
    wait_msgs(2);
  endtask
  // gain = 1 + corr / 2^25, rounding of the product left open by one lsb
  function automatic logic [11:0] exp_sent(input int f, input int t, input int c1, input int c2);
    longint corr;
    longint x;
    corr = longint'(c1 - 64) * t * 512 + longint'(2 * c2 - 511) * t * t;
    x = ((longint'(f) * (64'sd33554432 + corr)) >>> 25) + 2048;
    x = (x < 0) ? 0 : (x > 4095) ? 4095 : x;
    return 12'(x);
  endfunction
  function automatic logic [11:0] near(input logic [11:0] seen, input logic [11:0] exp);
    return (seen + 12'h001 == exp || seen == exp + 12'h001) ? seen : exp;
  endfunction
  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_startup();
    repeat (PO) @(posedge core_clk);
    check(24'(out_ready_q), 24'h000000);
    check(24'(rx_count), 24'h000000);
    check(24'(pwm_duty_q), 24'h000032);
    wr(STC_TC1_ADDR, 24'h000000);
    wr(STC_TC2_ADDR, 24'h000000);
    rd(STC_CTRL_ADDR, v);
    check(v, 24'h000000);
    wr(STC_TC1_ADDR, 24'hff0000);
    wr(STC_TC2_ADDR, 24'hff8000);
    rd(STC_TC1_ADDR, v);
    check(v, 24'hff0000);
    rd(STC_TC2_ADDR, v);
    check(v, 24'hff8000);
    rd(8'h0c, v);
    check(v, 24'h000000);
    $display("startup and registers done");
  endtask
  task automatic t_zero_dev();
    apply(300, 0);
    check(24'(rx_sent), 24'h00092c);
    check(24'(early_msg), 24'h000000);
    check(24'(out_ready_q), 24'h000001);
    $display("zero deviation done");
  endtask
  task automatic t_hot_cold();
    apply(1000, 10);
    check(24'(rx_sent), 24'(near(rx_sent, exp_sent(1000, 10, 255, 511))));
    apply(1000, -10);
    check(24'(rx_sent), 24'(near(rx_sent, exp_sent(1000, -10, 0, 0))));
    apply(-700, -3);
    check(24'(rx_sent), 24'(near(rx_sent, exp_sent(-700, -3, 0, 0))));
    $display("hot and cold selection done");
  endtask
  task automatic t_range();
    apply(2047, 100);
    check(24'(rx_sent), 24'h000fff);
    apply(-2048, 100);
    check(24'(rx_sent), 24'h000000);
    wr(STC_CTRL_ADDR, 24'h000001);
    wait_msgs(2);
    check(24'(rx_pwm), 24'h000032);
    apply(2047, 100);
    check(24'(rx_pwm), 24'h0003b5);
    $display("output range done");
  endtask
  task automatic t_repeat();
    int c;
    c = rx_count;
    wait_msgs(2);
    check(24'(rx_pwm), 24'h0003b5);
    check(24'(rx_count - c), 24'h000002);
    rd(STC_STAT_ADDR, v);
    check(v, 24'h00fff3);
    $display("message repeat done");
  endtask
  // spot codes that the decode assertions in the core watch
  task automatic t_spot();
    wr(STC_TC1_ADDR, 24'h400000);
    wr(STC_TC2_ADDR, 24'h7fc000);
    rd(STC_TC2_ADDR, v);
    check(v, 24'h7fc000);
    apply(1000, 3);
    check(24'(rx_sent), 24'(exp_sent(1000, 3, 64, 255)));
    apply(1000, -1);
    check(24'(rx_sent), 24'(exp_sent(1000, -1, 0, 256)));
    wr(STC_TC2_ADDR, 24'hffc000);
    apply(2000, 2);
    check(24'(rx_sent), 24'(exp_sent(2000, 2, 64, 511)));
    $display("spot codes done");
  endtask
  // cut a hang short
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      n_errors++;
      print_verdict();
    end
  end
  // main sequence
  initial begin
    repeat (10) @(posedge core_clk);
    rst <= 1'b0;
    t_startup();
    t_zero_dev();
    t_hot_cold();
    t_range();
    t_repeat();
    t_spot();
    print_verdict();
  end
endmodule // test_sensitivity_temp_compensation
